// [rtl/pmfm_pkg.sv]
package pmfm_pkg;
    // core clock rate and derived timing
    localparam int CLK_HZ = 40000000;
    localparam int SHORT_DEGLITCH_US = 250;
    localparam int SHORT_RECOVERY_S = 2;
    localparam int OVP_RELEASE_US = 32;
    localparam int ALERT_PULSE_US = 128;
    localparam int MONITOR_WAIT_MS = 2;
    localparam int HOST_READY_MS = 5;
    localparam int UV_DEGLITCH_US = 32;
    localparam int SHORT_DEGLITCH_CYC = SHORT_DEGLITCH_US * (CLK_HZ / 1000000);
    localparam int SHORT_RECOVERY_CYC = SHORT_RECOVERY_S * CLK_HZ;
    localparam int OVP_RELEASE_CYC = OVP_RELEASE_US * (CLK_HZ / 1000000);
    localparam int ALERT_PULSE_CYC = ALERT_PULSE_US * (CLK_HZ / 1000000);
    localparam int MONITOR_WAIT_CYC = MONITOR_WAIT_MS * (CLK_HZ / 1000);
    localparam int HOST_READY_CYC = HOST_READY_MS * (CLK_HZ / 1000);
    localparam int UV_DEGLITCH_CYC = UV_DEGLITCH_US * (CLK_HZ / 1000000);
    localparam int TMR_W = 27;

    // battery monitor code: 60% to 100% in 2% steps, 21 codes
    localparam int MON_PCT_MIN = 60;
    localparam int MON_PCT_MAX = 100;
    localparam int MON_PCT_STEP = 2;
    localparam logic [4:0] MON_CODE_MAX = 5'h14;
    // power limit loop: 4.2 V to 4.9 V in 100 mV steps, code 0 = 4.2 V
    localparam logic [2:0] LIMIT_CODE_MAX = 3'h7;

    // fault bit positions
    localparam int FLT_SLEEP = 0;
    localparam int FLT_OVP = 1;
    localparam int FLT_UV = 2;
    localparam int FLT_W = 3;

    typedef enum logic [6:0] {
        PMFM_SHIP = 7'h01,
        PMFM_HIZ = 7'h02,
        PMFM_ACTBAT = 7'h04,
        PMFM_CHARGE = 7'h08,
        PMFM_SLEEP = 7'h10,
        PMFM_OVP = 7'h20,
        PMFM_NOCHG = 7'h40
    } pmfm_mode_e;

    // analog comparator results
    typedef struct packed {
        logic inAboveLockout; // input above undervoltage lockout
        logic inAboveSleep; // input above battery plus sleep offset
        logic inOverVoltage; // input above overvoltage level
        logic batAboveUvlo; // battery above programmed threshold
        logic batAboveUvloHyst; // battery above threshold plus hysteresis
        logic batAboveMaxUvlo; // battery above highest selectable threshold
        logic batAboveMinUvlo; // battery above lowest selectable threshold
        logic shortCircuit; // discharge current limit reached
        logic limitLoopHit; // input at power limit threshold
        logic sysInRegulation; // system rail at programmed level
    } pmfm_analog_s;

    // host control bits
    typedef struct packed {
        logic shipEntryRequest;
        logic highImpedanceRequest;
        logic chargeEnable;
        logic loadSwitchEnable;
        logic batteryMonitorTrigger;
        logic limitLoopDisable;
        logic [2:0] limitLoopCode;
        logic doubleTimer;
        logic faultRead;
    } pmfm_ctrl_s;
endpackage

// [rtl/pmfm_timer.sv]
`timescale 1ns/10ps
// level qualifier: done after LIMIT cycles held
module pmfm_timer #(
    parameter int LIMIT = 16
) (
    input wire logic core_clk, // core clock
    input wire logic arst_n, // async reset, active low
    input wire logic run, // level to qualify
    output logic done // held long enough
);
    import pmfm_pkg::*;
    logic [TMR_W-1:0] count;
    localparam logic [TMR_W-1:0] LIM = LIMIT[TMR_W-1:0];

    // saturates so done holds with run
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else if (!run) begin
            count <= '0;
        end else if (count != LIM) begin
            count <= count + 1'b1;
        end
    end

    assign done = run && (count == LIM);
endmodule

// [rtl/power_mode_fault_manager.sv]
`timescale 1ns/10ps
module power_mode_fault_manager #(
    parameter int SHORT_RECOVERY = pmfm_pkg::SHORT_RECOVERY_CYC, // retry wait
    parameter int HOST_READY = pmfm_pkg::HOST_READY_CYC, // host enable delay
    parameter int MONITOR_WAIT = pmfm_pkg::MONITOR_WAIT_CYC // monitor settle
) (
    input wire logic core_clk, // core clock, 40 MHz
    input wire logic arst_n, // async reset, active low
    input wire pmfm_pkg::pmfm_analog_s analog, // comparator results
    input wire pmfm_pkg::pmfm_ctrl_s ctrl, // host control bits
    input wire logic charge_disable_pin, // charge disable pin
    input wire logic pushbutton_input, // pushbutton, high while pressed
    input wire logic load_switch_control_pin, // load switch pin
    input wire logic [4:0] batteryRatioCode, // battery vs regulation, 2% code
    output pmfm_pkg::pmfm_mode_e mode, // current operating mode
    output logic dischargeSwitchOn, // battery discharge switch
    output logic chargeEnabled, // charger enabled
    output logic systemRailOn, // system rail output on
    output logic load_switch_output, // load switch output on
    output logic hostLinkEnable, // serial host link usable
    output logic hostInterfacesActive, // host pins active
    output logic alertPulse, // alert output level
    output logic [pmfm_pkg::FLT_W-1:0] faultBits, // sticky fault bits
    output logic limitLoopStatus, // power limit loop active
    output logic terminationDisable, // charge termination blocked
    output logic safetyTimerExtend, // safety timer slowed
    output logic [2:0] limitLoopThreshold, // applied threshold code
    output logic [4:0] battery_monitor_result, // latched monitor code
    output logic monitorBusy // reading in progress
);
    import pmfm_pkg::*;

    pmfm_mode_e next_mode;
    logic inValid;
    logic wasPressed;
    logic shipArmed;
    logic cdPrev;
    logic shortQual;
    logic ovpReleased;
    logic uvQual;
    logic uvSeen;
    logic inRecovery;
    logic [TMR_W-1:0] recCount;
    logic batOk;
    logic [TMR_W-1:0] readyCount;
    logic [TMR_W-1:0] alertCount;
    logic alertStart;
    logic [TMR_W-1:0] monCount;
    logic monStart;
    logic [FLT_W-1:0] faultEvent;
    logic [FLT_W-1:0] faultCond;
    logic faultReadSeen;

    assign inValid = analog.inAboveLockout && analog.inAboveSleep && !analog.inOverVoltage;

    // deglitch timers
    pmfm_timer #(.LIMIT(SHORT_DEGLITCH_CYC)) uShort (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .run(analog.shortCircuit && dischargeSwitchOn && !inValid),
        .done(shortQual)
    );
    pmfm_timer #(.LIMIT(OVP_RELEASE_CYC)) uOvp (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .run(mode == PMFM_OVP && !analog.inOverVoltage),
        .done(ovpReleased)
    );
    pmfm_timer #(.LIMIT(UV_DEGLITCH_CYC)) uUv (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .run(!analog.inAboveLockout),
        .done(uvQual)
    );

    // ship request follows the host bit
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            shipArmed <= 1'b0;
        end else begin
            shipArmed <= ctrl.shipEntryRequest;
        end
    end

    // raw button edge, no debounce
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wasPressed <= 1'b0;
            cdPrev <= 1'b0;
        end else begin
            wasPressed <= pushbutton_input;
            cdPrev <= charge_disable_pin;
        end
    end

    // mode selection
    always_comb begin
        next_mode = mode;
        case (mode)
            PMFM_SHIP: begin
                // lockout, raw button release and highest battery threshold matter
                if (analog.inAboveLockout) begin
                    next_mode = PMFM_CHARGE;
                end else if (wasPressed && !pushbutton_input && analog.batAboveMaxUvlo) begin
                    next_mode = PMFM_ACTBAT;
                end
            end
            PMFM_OVP: begin
                if (ovpReleased) begin
                    next_mode = PMFM_CHARGE;
                end
            end
            default: begin
                if (analog.inOverVoltage) begin
                    next_mode = PMFM_OVP;
                end else if (!analog.inAboveLockout) begin
                    if (shipArmed && charge_disable_pin) begin
                        next_mode = PMFM_SHIP;
                    end else if (!charge_disable_pin || ctrl.highImpedanceRequest) begin
                        next_mode = PMFM_HIZ;
                    end else begin
                        next_mode = PMFM_ACTBAT;
                    end
                    // pin rising edge leaves quiet state
                    if (mode == PMFM_HIZ && charge_disable_pin && !cdPrev) begin
                        next_mode = PMFM_ACTBAT;
                    end
                end else if (!analog.inAboveSleep) begin
                    next_mode = PMFM_SLEEP;
                end else if (charge_disable_pin || !ctrl.chargeEnable) begin
                    next_mode = PMFM_NOCHG;
                end else begin
                    next_mode = PMFM_CHARGE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode <= PMFM_ACTBAT;
        end else begin
            mode <= next_mode;
        end
    end

    // short circuit recovery interval
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            inRecovery <= 1'b0;
            recCount <= '0;
        end else if (inRecovery) begin
            if (recCount == SHORT_RECOVERY[TMR_W-1:0] - 1'b1) begin
                inRecovery <= 1'b0;
            end
            recCount <= recCount + 1'b1;
        end else if (shortQual) begin
            inRecovery <= 1'b1;
            recCount <= '0;
        end
    end

    // battery undervoltage with hysteresis
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            batOk <= 1'b0;
        end else if (!analog.batAboveUvlo) begin
            batOk <= 1'b0;
        end else if (analog.batAboveUvloHyst) begin
            batOk <= 1'b1;
        end
    end

    // discharge switch and charger enables
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dischargeSwitchOn <= 1'b0;
            chargeEnabled <= 1'b0;
            systemRailOn <= 1'b0;
        end else begin
            chargeEnabled <= (next_mode == PMFM_CHARGE);
            systemRailOn <= (next_mode != PMFM_SHIP);
            case (next_mode)
                PMFM_SHIP: dischargeSwitchOn <= 1'b0;
                PMFM_SLEEP, PMFM_OVP: dischargeSwitchOn <= !inRecovery;
                PMFM_CHARGE, PMFM_NOCHG: begin
                    // supplement kept above lowest level
                    dischargeSwitchOn <= analog.batAboveMinUvlo && !inRecovery;
                end
                default: dischargeSwitchOn <= batOk && !inRecovery && !shortQual;
            endcase
        end
    end

    // pin or host enable, kept in high impedance
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            load_switch_output <= 1'b0;
        end else begin
            load_switch_output <= (mode != PMFM_SHIP) &&
                (ctrl.loadSwitchEnable || load_switch_control_pin);
        end
    end

    // link off on quiet request; pin toggle restores
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hostLinkEnable <= 1'b1;
        end else if (mode == PMFM_SHIP) begin
            hostLinkEnable <= 1'b0;
        end else if (charge_disable_pin != cdPrev) begin
            hostLinkEnable <= 1'b1;
        end else if (ctrl.highImpedanceRequest && !analog.inAboveLockout) begin
            hostLinkEnable <= 1'b0;
        end else if (mode != PMFM_HIZ) begin
            hostLinkEnable <= 1'b1;
        end
    end

    // host pins up once rail has held
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            readyCount <= '0;
            hostInterfacesActive <= 1'b0;
        end else if (!analog.sysInRegulation) begin
            readyCount <= '0;
            hostInterfacesActive <= 1'b0;
        end else if (readyCount == HOST_READY[TMR_W-1:0] - 1'b1) begin
            hostInterfacesActive <= 1'b1;
        end else begin
            readyCount <= readyCount + 1'b1;
        end
    end

    // undervoltage seen once per drop
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            uvSeen <= 1'b0;
        end else begin
            uvSeen <= uvQual;
        end
    end

    always_comb begin
        faultEvent = '0;
        faultEvent[FLT_SLEEP] = (next_mode == PMFM_SLEEP) && (mode != PMFM_SLEEP);
        faultEvent[FLT_OVP] = (next_mode == PMFM_OVP) && (mode != PMFM_OVP);
        faultEvent[FLT_UV] = uvQual && !uvSeen && (mode != PMFM_SHIP);
        faultCond = '0;
        faultCond[FLT_SLEEP] = (mode == PMFM_SLEEP);
        faultCond[FLT_OVP] = (mode == PMFM_OVP);
        faultCond[FLT_UV] = !analog.inAboveLockout;
    end

    assign alertStart = |faultEvent;

    // read remembered; new fault event clears it, winning over a read
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            faultReadSeen <= 1'b0;
        end else if (alertStart) begin
            faultReadSeen <= 1'b0;
        end else if (ctrl.faultRead) begin
            faultReadSeen <= 1'b1;
        end else if (faultBits == '0) begin
            faultReadSeen <= 1'b0;
        end
    end

    // per-bit sticky fault
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            faultBits <= '0;
        end else begin
            for (int i = 0; i < FLT_W; i++) begin
                if (faultEvent[i]) begin
                    faultBits[i] <= 1'b1;
                end else if ((faultReadSeen || ctrl.faultRead) && !faultCond[i]) begin
                    faultBits[i] <= 1'b0;
                end
            end
        end
    end

    // fixed alert pulse; new event restarts it
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            alertCount <= '0;
            alertPulse <= 1'b0;
        end else if (alertStart) begin
            alertCount <= '0;
            alertPulse <= 1'b1;
        end else if (alertPulse) begin
            if (alertCount == ALERT_PULSE_CYC[TMR_W-1:0] - 1'b1) begin
                alertPulse <= 1'b0;
            end
            alertCount <= alertCount + 1'b1;
        end
    end

    // power limit loop status and side effects
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            limitLoopStatus <= 1'b0;
            terminationDisable <= 1'b0;
            safetyTimerExtend <= 1'b0;
            limitLoopThreshold <= '0;
        end else begin
            limitLoopThreshold <= (ctrl.limitLoopCode > LIMIT_CODE_MAX) ?
                LIMIT_CODE_MAX : ctrl.limitLoopCode;
            limitLoopStatus <= !ctrl.limitLoopDisable && analog.limitLoopHit &&
                chargeEnabled;
            terminationDisable <= !ctrl.limitLoopDisable && analog.limitLoopHit;
            safetyTimerExtend <= !ctrl.limitLoopDisable && analog.limitLoopHit &&
                ctrl.doubleTimer;
        end
    end

    // monitor: host trigger or high impedance entry
    assign monStart = (ctrl.batteryMonitorTrigger ||
        (next_mode == PMFM_HIZ && mode != PMFM_HIZ)) && !monitorBusy;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            monitorBusy <= 1'b0;
            monCount <= '0;
            battery_monitor_result <= '0;
        end else if (monStart) begin
            monitorBusy <= 1'b1;
            monCount <= '0;
        end else if (monitorBusy) begin
            monCount <= monCount + 1'b1;
            if (monCount == MONITOR_WAIT[TMR_W-1:0] - 1'b1) begin
                monitorBusy <= 1'b0;
                // code k means (60 + 2k)% of regulation voltage
                battery_monitor_result <= (batteryRatioCode > MON_CODE_MAX) ?
                    MON_CODE_MAX : batteryRatioCode;
            end
        end
    end
endmodule

// [tb/pmfm_assertions.sv]
`timescale 1ns/10ps
module pmfm_assertions #(
    parameter int MONITOR_WAIT = 100
) (
    input wire logic core_clk, // core clock
    input wire logic arst_n, // async reset
    input wire pmfm_pkg::pmfm_ctrl_s ctrl, // host bits
    input wire pmfm_pkg::pmfm_mode_e mode, // mode
    input wire logic dischargeSwitchOn, // discharge switch
    input wire logic systemRailOn, // rail on
    input wire logic hostLinkEnable, // host link
    input wire logic alertPulse, // alert
    input wire logic [pmfm_pkg::FLT_W-1:0] faultBits, // faults
    input wire logic limitLoopStatus, // loop active
    input wire logic terminationDisable, // termination off
    input wire logic monitorBusy // reading
);
    import pmfm_pkg::*;
    int alertLen;
    int busyLen;
    // run lengths
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            alertLen <= 0;
            busyLen <= 0;
        end else begin
            alertLen <= alertPulse ? alertLen + 1 : 0;
            busyLen <= monitorBusy ? busyLen + 1 : 0;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_sleep_entry_pulse: assert property (
        (mode == PMFM_SLEEP && $past(mode) != PMFM_SLEEP)
        |-> alertPulse && faultBits[FLT_SLEEP] && dischargeSwitchOn)
        else $error("sleep entry incomplete");
    a_ovp_entry_pulse: assert property (
        (mode == PMFM_OVP && $past(mode) != PMFM_OVP)
        |-> alertPulse && faultBits[FLT_OVP] && dischargeSwitchOn)
        else $error("overvoltage entry incomplete");
    a_alert_width: assert property ($fell(alertPulse) |-> alertLen == ALERT_PULSE_CYC)
        else $error("alert width wrong");
    a_sleep_fault_hold: assert property (
        $fell(faultBits[FLT_SLEEP]) |-> $past(mode) != PMFM_SLEEP)
        else $error("sleep fault cleared early");
    a_ovp_fault_hold: assert property (
        $fell(faultBits[FLT_OVP]) |-> $past(mode) != PMFM_OVP)
        else $error("overvoltage fault cleared early");
    a_ship_outputs_off: assert property (
        mode == PMFM_SHIP |-> !dischargeSwitchOn && !systemRailOn)
        else $error("ship mode output on");
    a_limit_no_term: assert property (limitLoopStatus |-> terminationDisable)
        else $error("termination allowed in limit loop");
    a_hiz_link_off: assert property (
        ($rose(mode == PMFM_HIZ) && $past(ctrl.highImpedanceRequest)) |-> !hostLinkEnable)
        else $error("host link left on");
    a_monitor_wait: assert property ($fell(monitorBusy) |-> busyLen == MONITOR_WAIT)
        else $error("monitor reading too short");
    c_sleep: cover property (mode == PMFM_SLEEP && alertPulse);
    c_ovp: cover property (mode == PMFM_OVP);
    c_ship: cover property (mode == PMFM_SHIP);
    c_monitor: cover property ($fell(monitorBusy));
endmodule
bind power_mode_fault_manager pmfm_assertions #(.MONITOR_WAIT(MONITOR_WAIT)) uChk (
    .core_clk(core_clk), .arst_n(arst_n), .ctrl(ctrl), .mode(mode),
    .dischargeSwitchOn(dischargeSwitchOn), .systemRailOn(systemRailOn),
    .hostLinkEnable(hostLinkEnable), .alertPulse(alertPulse), .faultBits(faultBits),
    .limitLoopStatus(limitLoopStatus), .terminationDisable(terminationDisable),
    .monitorBusy(monitorBusy));

// [tb/pmfm_host_model.sv]
`timescale 1ns/10ps
module pmfm_host_model (
    input wire logic core_clk, // core clock
    input wire logic arst_n, // async reset
    input wire pmfm_pkg::pmfm_ctrl_s cfg, // wanted settings
    input wire logic readReq, // level, read faults
    output pmfm_pkg::pmfm_ctrl_s ctrl // bits to the block
);
    import pmfm_pkg::*;
    logic reqSeen;
    logic strobe;
    // one strobe per request
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reqSeen <= 1'b0;
            strobe <= 1'b0;
        end else begin
            reqSeen <= readReq;
            strobe <= readReq && !reqSeen;
        end
    end
    // charge paused for a quiet reading
    always_comb begin
        ctrl = cfg;
        ctrl.chargeEnable = cfg.chargeEnable && !cfg.batteryMonitorTrigger;
        ctrl.faultRead = strobe;
    end
endmodule

// [tb/power_mode_fault_manager_tb.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin nMismatch++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
`define WAITC(c, lim) begin checkCount++; for (n = 0; n < (lim) && !(c); n++) step(); if (!(c)) hang(); end
module power_mode_fault_manager_tb;
    import pmfm_pkg::*;
    localparam int RECOV = 200;
    localparam int READY = 50;
    localparam int MWAIT = 100;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic readReq = 1'b0;
    logic cdPin = 1'b0;
    logic button = 1'b0;
    logic lsPin = 1'b0;
    logic [4:0] ratio = 5'h17;
    pmfm_analog_s analog;
    pmfm_ctrl_s cfg;
    pmfm_ctrl_s ctrl;
    pmfm_mode_e mode;
    logic dischargeSwitchOn, chargeEnabled, load_switch_output, hostLinkEnable;
    logic hostInterfacesActive, alertPulse, limitLoopStatus, terminationDisable;
    logic safetyTimerExtend, monitorBusy;
    logic [FLT_W-1:0] faultBits;
    logic [2:0] limitLoopThreshold;
    logic [4:0] battery_monitor_result;
    int nMismatch = 0;
    int checkCount = 0;
    int n;
    // 40 MHz
    always #12.5 core_clk = ~core_clk;
    pmfm_host_model host (.core_clk(core_clk), .arst_n(arst_n), .cfg(cfg), .readReq(readReq),
        .ctrl(ctrl));
    power_mode_fault_manager #(.SHORT_RECOVERY(RECOV), .HOST_READY(READY),
        .MONITOR_WAIT(MWAIT)) uut (.core_clk(core_clk), .arst_n(arst_n), .analog(analog),
        .ctrl(ctrl), .charge_disable_pin(cdPin), .pushbutton_input(button),
        .load_switch_control_pin(lsPin), .batteryRatioCode(ratio), .mode(mode),
        .dischargeSwitchOn(dischargeSwitchOn), .chargeEnabled(chargeEnabled), .systemRailOn(),
        .load_switch_output(load_switch_output), .hostLinkEnable(hostLinkEnable),
        .hostInterfacesActive(hostInterfacesActive), .alertPulse(alertPulse),
        .faultBits(faultBits), .limitLoopStatus(limitLoopStatus),
        .terminationDisable(terminationDisable), .safetyTimerExtend(safetyTimerExtend),
        .limitLoopThreshold(limitLoopThreshold), .monitorBusy(monitorBusy),
        .battery_monitor_result(battery_monitor_result));
    // settled sample
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    task automatic finalReport();
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic hang();
        nMismatch++;
        $display("Error wait expected done seen timeout");
        finalReport();
    endtask
    task automatic hostRead();
        @(posedge core_clk) readReq <= 1'b1;
        @(posedge core_clk) readReq <= 1'b0;
        repeat (3) step();
    endtask
    task automatic scSleep();
        int w;
        @(posedge core_clk) analog.inAboveSleep <= 1'b0;
        `WAITC(mode === PMFM_SLEEP, 10)
        `CHK("sleepAlert", 1'b1, alertPulse)
        `CHK("sleepFault", 1'b1, faultBits[FLT_SLEEP])
        `CHK("sleepSwitch", 1'b1, dischargeSwitchOn)
        for (w = 0; alertPulse === 1'b1 && w < 6000; w++) step();
        `CHK("alertWidth", ALERT_PULSE_CYC, w)
        hostRead();
        `CHK("sleepKept", 1'b1, faultBits[FLT_SLEEP])
        @(posedge core_clk) analog.inAboveSleep <= 1'b1;
        `WAITC(mode !== PMFM_SLEEP, 10)
        `CHK("restart", PMFM_CHARGE, mode)
        `WAITC(faultBits[FLT_SLEEP] === 1'b0, 5)
    endtask
    task automatic scOvp();
        @(posedge core_clk) analog.inOverVoltage <= 1'b1;
        `WAITC(mode === PMFM_OVP, 10)
        `CHK("ovpAlert", 1'b1, alertPulse)
        `CHK("ovpFault", 1'b1, faultBits[FLT_OVP])
        `CHK("ovpSwitch", 1'b1, dischargeSwitchOn)
        hostRead();
        @(posedge core_clk) analog.inOverVoltage <= 1'b0;
        repeat (OVP_RELEASE_CYC - 8) step();
        `CHK("ovpHeld", PMFM_OVP, mode)
        `WAITC(mode !== PMFM_OVP, 20)
        `WAITC(faultBits[FLT_OVP] === 1'b0, 5)
        `WAITC(alertPulse === 1'b0, 6000)
    endtask
    task automatic scUv();
        // input gone
        @(posedge core_clk) analog[9:8] <= 2'b00;
        repeat (UV_DEGLITCH_CYC - 8) step();
        `CHK("uvEarly", 1'b0, faultBits[FLT_UV])
        `WAITC(faultBits[FLT_UV] === 1'b1, 20)
        `CHK("uvAlert", 1'b1, alertPulse)
        `WAITC(mode === PMFM_HIZ && monitorBusy === 1'b0, MWAIT + 20)
        `CHK("monSaturate", MON_CODE_MAX, battery_monitor_result)
    endtask
    task automatic scHiz();
        @(posedge core_clk) lsPin <= 1'b1;
        `WAITC(load_switch_output === 1'b1, 10)
        @(posedge core_clk) cdPin <= 1'b1;
        `WAITC(mode === PMFM_ACTBAT, 10)
        @(posedge core_clk) cfg.highImpedanceRequest <= 1'b1;
        `WAITC(mode === PMFM_HIZ, MWAIT + 20)
        `CHK("linkOff", 1'b0, hostLinkEnable)
        @(posedge core_clk) begin
            cfg.highImpedanceRequest <= 1'b0;
            cdPin <= 1'b0;
            lsPin <= 1'b0;
        end
        repeat (3) step();
        @(posedge core_clk) cdPin <= 1'b1;
        `WAITC(mode === PMFM_ACTBAT && hostLinkEnable === 1'b1, 10)
    endtask
    task automatic scBattery();
        @(posedge core_clk) analog.shortCircuit <= 1'b1;
        repeat (SHORT_DEGLITCH_CYC - 10) step();
        `CHK("shortEarly", 1'b1, dischargeSwitchOn)
        `WAITC(dischargeSwitchOn === 1'b0, 20)
        repeat (RECOV - 10) step();
        `CHK("recovering", 1'b0, dischargeSwitchOn)
        `WAITC(dischargeSwitchOn === 1'b1, 20)
        @(posedge core_clk) analog.shortCircuit <= 1'b0;
        @(posedge core_clk) analog[6:5] <= 2'b00;
        `WAITC(dischargeSwitchOn === 1'b0, 50)
        @(posedge core_clk) analog.batAboveUvlo <= 1'b1;
        repeat (20) step();
        `CHK("hysteresis", 1'b0, dischargeSwitchOn)
        @(posedge core_clk) analog.batAboveUvloHyst <= 1'b1;
        `WAITC(dischargeSwitchOn === 1'b1, 50)
    endtask
    task automatic scMonitor();
        @(posedge core_clk) begin
            cfg.batteryMonitorTrigger <= 1'b1;
            ratio <= 5'h05;
        end
        `WAITC(monitorBusy === 1'b1, 5)
        @(posedge core_clk) cfg.batteryMonitorTrigger <= 1'b0;
        repeat (MWAIT - 10) step();
        `CHK("monOld", MON_CODE_MAX, battery_monitor_result)
        `WAITC(monitorBusy === 1'b0, 20)
        `CHK("monNew", 5'h05, battery_monitor_result)
    endtask
    task automatic scLimit();
        @(posedge core_clk) begin
            analog[9:8] <= 2'b11;
            cdPin <= 1'b0;
            cfg.limitLoopCode <= 3'h7;
            cfg.doubleTimer <= 1'b1;
            analog.limitLoopHit <= 1'b1;
        end
        `WAITC(mode === PMFM_CHARGE && limitLoopStatus === 1'b1, 20)
        `CHK("supplement", 1'b1, dischargeSwitchOn)
        `CHK("noTerm", 1'b1, terminationDisable)
        `CHK("timerExt", 1'b1, safetyTimerExtend)
        `CHK("threshold", 3'h7, limitLoopThreshold)
        @(posedge core_clk) cfg.limitLoopDisable <= 1'b1;
        `WAITC(limitLoopStatus === 1'b0, 10)
    endtask
    task automatic scShip();
        @(posedge core_clk) cdPin <= 1'b1;
        `WAITC(mode === PMFM_NOCHG, 10)
        `CHK("chargeOff", 1'b0, chargeEnabled)
        @(posedge core_clk) cfg.shipEntryRequest <= 1'b1;
        repeat (20) step();
        `CHK("shipDeferred", PMFM_NOCHG, mode)
        @(posedge core_clk) analog[9:8] <= 2'b00;
        `WAITC(mode === PMFM_SHIP, MWAIT + 40)
        `CHK("shipSwitch", 1'b0, dischargeSwitchOn)
        @(posedge core_clk) analog.batAboveMaxUvlo <= 1'b0;
        @(posedge core_clk) button <= 1'b1;
        repeat (20) step();
        @(posedge core_clk) button <= 1'b0;
        repeat (20) step();
        `CHK("weakBattery", PMFM_SHIP, mode)
        @(posedge core_clk) begin
            analog[9:8] <= 2'b11;
            cfg.shipEntryRequest <= 1'b0;
        end
        `WAITC(mode !== PMFM_SHIP, 20)
    endtask
    initial begin
        analog = 10'h379;
        cfg = 11'h100;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        `WAITC(hostInterfacesActive === 1'b1, READY + 5)
        `WAITC(mode === PMFM_CHARGE, 10)
        scSleep();
        scOvp();
        scUv();
        scHiz();
        scBattery();
        scMonitor();
        scLimit();
        scShip();
        finalReport();
    end
endmodule
